// ===== hdl/iem_top.sv
// Interrupt enable logic: enable register, sticky status, clear and
// interrupt-output enable registers, reached over classic Wishbone.
// Assumes event pulses are one cycle wide and synchronous to ref_clk_i.
//
// Contract
// - A status bit latches only if its enable was set when the event came.
// - Clearing an enable leaves pending status alone and only blocks later events.
// - The enable register is 32-bit read/write at 0x36c and every defined bit resets to 0.
// - Bit 29 enables the frame period event.
// - Bit 28 enables the frame start event.
// - Bits 24 to 27 enable input converters 1 to 4 conversion done, in order.
// - Bits 16 and 17 enable output converters 1 and 2 convert events.
// - Bit 12 enables the input sequencer frame done event.
// - Bit 8 enables the input sequencer transfer end event.
// - Bit 4 enables the output sequencer frame done event.
// - Bit 0 enables the output sequencer buffer done event.
`timescale 1ns/1ps
`default_nettype none
module iem_top
  import iem_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire iem_event_type events_i,
  output logic [31:0] enable_o,
  output logic irq_o
);
  // Bus request, answer and register state.
  iem_wb_req_type req;
  logic ack;
  logic next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [31:0] enable;
  logic [31:0] event_vec;
  logic [31:0] status;
  logic [31:0] irq_en;
  logic [31:0] next_irq_en;
  logic [31:0] clear_vec;
  logic take;
  logic wr_enable;
  logic wr_clear;
  logic wr_irq_en;
  logic [31:0] byte_mask;

  // Gather the bus inputs into one request word.
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: wb_adr_i, dat: wb_dat_i};

  // A request is taken once, in the cycle before ack; ack drops after one cycle.
  assign take = req.cyc && req.stb && !ack;
  assign wr_enable = take && req.we && (req.adr == IEM_ENABLE_OFS);
  assign wr_clear = take && req.we && (req.adr == IEM_CLEAR_OFS);
  assign wr_irq_en = take && req.we && (req.adr == IEM_IRQ_EN_OFS);
  assign byte_mask = {{8{req.sel[3]}}, {8{req.sel[2]}}, {8{req.sel[1]}}, {8{req.sel[0]}}};

  // Enable register in byte lanes; reserved bits are never stored.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      iem_byte_reg u_lane (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .wr_i(wr_enable && req.sel[g]),
        .din_i(req.dat[8*g +: 8]),
        .mask_i(IEM_ENABLE_MASK[8*g +: 8]),
        .q_o(enable[8*g +: 8])
      );
    end
  endgenerate

  // Place each event on its enable bit position.
  always_comb begin
    event_vec = IEM_ZERO_WORD;
    event_vec[IEM_FRAME_PERIOD_BIT] = events_i.frame_period;
    event_vec[IEM_FRAME_START_BIT] = events_i.frame_start;
    event_vec[IEM_IN_CONV_LSB +: 4] = events_i.in_conv_done;
    event_vec[IEM_OUT_CONV_LSB +: 2] = events_i.out_conv_event;
    event_vec[IEM_IN_SEQ_FRAME_BIT] = events_i.in_seq_frame_done;
    event_vec[IEM_IN_SEQ_XFER_BIT] = events_i.in_seq_transfer_end;
    event_vec[IEM_OUT_SEQ_FRAME_BIT] = events_i.out_seq_frame_done;
    event_vec[IEM_OUT_SEQ_BUF_BIT] = events_i.out_seq_buffer_done;
  end

  // Ones written to the clear register drop status bits; zeros leave them alone.
  assign clear_vec = wr_clear ? (req.dat & byte_mask) : IEM_ZERO_WORD;

  // Sticky status bits gated by the current enable value.
  generate
    for (g = 0; g < 32; g++) begin : g_stat
      if (IEM_ENABLE_MASK[g]) begin : g_used
        iem_status_bit u_bit (
          .ref_clk_i(ref_clk_i),
          .nrst_i(nrst_i),
          .event_i(event_vec[g]),
          .enable_i(enable[g]),
          .clear_i(clear_vec[g]),
          .status_o(status[g])
        );
      end else begin : g_none
        assign status[g] = 1'b0;
      end
    end
  endgenerate

  // Bus answer and interrupt-output enable register.
  always_comb begin
    next_ack = take;
    next_irq_en = irq_en;
    if (wr_irq_en) begin
      next_irq_en = ((irq_en & ~byte_mask) | (req.dat & byte_mask)) & IEM_ENABLE_MASK;
    end
    next_rdata = IEM_ZERO_WORD;
    if (take && !req.we) begin
      case (req.adr)
        IEM_ENABLE_OFS: next_rdata = enable;
        IEM_STATUS_OFS: next_rdata = status;
        IEM_IRQ_EN_OFS: next_rdata = irq_en;
        default: next_rdata = IEM_ZERO_WORD;
      endcase
    end
  end

  // Bus answer, read data and interrupt-output enables are only registered here.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack <= 1'b0;
      rdata <= IEM_ZERO_WORD;
      irq_en <= IEM_STATUS_RST;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      irq_en <= next_irq_en;
    end
  end

  // The interrupt is a level, so software may poll it as well as take it.
  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;
  assign enable_o = enable;
  assign irq_o = |(status & irq_en);

  // Checks.
  chk_enable_gates_set: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (!$past(status[IEM_FRAME_PERIOD_BIT]) && status[IEM_FRAME_PERIOD_BIT])
      |-> $past(enable[IEM_FRAME_PERIOD_BIT] && events_i.frame_period))
    else $error("Frame period status set without enabled event.");
  chk_disabled_no_set: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (events_i.frame_start && !enable[IEM_FRAME_START_BIT] && !status[IEM_FRAME_START_BIT])
      |=> !status[IEM_FRAME_START_BIT])
    else $error("Disabled frame start event set status.");
  chk_pending_kept: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (status[IEM_IN_CONV_LSB] && !clear_vec[IEM_IN_CONV_LSB]) |=> status[IEM_IN_CONV_LSB])
    else $error("Pending status lost without a clear.");
  chk_enabled_sets: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (events_i.out_conv_event[1] && enable[IEM_OUT_CONV_LSB + 1])
      |=> status[IEM_OUT_CONV_LSB + 1])
    else $error("Enabled converter event did not set status.");
  chk_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (enable & ~IEM_ENABLE_MASK) == IEM_ZERO_WORD)
    else $error("Reserved enable bit is set.");
  sequence s_write_enable;
    wr_enable && (req.sel == 4'hf);
  endsequence
  chk_enable_write: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_write_enable |=> (enable == ($past(req.dat) & IEM_ENABLE_MASK)))
    else $error("Enable register did not take the written value.");
  chk_seq_sets: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (events_i.in_seq_transfer_end && enable[IEM_IN_SEQ_XFER_BIT])
      |=> status[IEM_IN_SEQ_XFER_BIT])
    else $error("Transfer end event did not set status.");
  chk_buf_sets: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (events_i.out_seq_buffer_done && enable[IEM_OUT_SEQ_BUF_BIT])
      |=> status[IEM_OUT_SEQ_BUF_BIT])
    else $error("Buffer done event did not set status.");
  chk_ack_once: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (wb_cyc_i && wb_stb_i && !ack) |=> ack ##1 !ack)
    else $error("Bus ack not a single cycle.");

  // Each source reaches its own status bit through its own enable bit.
  chk_period_sets: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (events_i.frame_period && enable[IEM_FRAME_PERIOD_BIT])
      |=> status[IEM_FRAME_PERIOD_BIT])
    else $error("Frame period event did not set status.");
  chk_start_sets: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (events_i.frame_start && enable[IEM_FRAME_START_BIT])
      |=> status[IEM_FRAME_START_BIT])
    else $error("Frame start event did not set status.");
  chk_conv_first_sets: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (events_i.in_conv_done[0] && enable[IEM_IN_CONV_LSB])
      |=> status[IEM_IN_CONV_LSB])
    else $error("First input converter event did not set status.");
  chk_conv_last_sets: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (events_i.in_conv_done[3] && enable[IEM_IN_CONV_LSB + 3])
      |=> status[IEM_IN_CONV_LSB + 3])
    else $error("Last input converter event did not set status.");
  chk_out_first_sets: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (events_i.out_conv_event[0] && enable[IEM_OUT_CONV_LSB])
      |=> status[IEM_OUT_CONV_LSB])
    else $error("First output converter event did not set status.");
  chk_in_frame_sets: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (events_i.in_seq_frame_done && enable[IEM_IN_SEQ_FRAME_BIT])
      |=> status[IEM_IN_SEQ_FRAME_BIT])
    else $error("Input sequencer frame event did not set status.");
  chk_out_frame_sets: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (events_i.out_seq_frame_done && enable[IEM_OUT_SEQ_FRAME_BIT])
      |=> status[IEM_OUT_SEQ_FRAME_BIT])
    else $error("Output sequencer frame event did not set status.");

  // An event that finds its gate shut leaves a clear status bit clear.
  chk_conv_shut: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (events_i.in_conv_done[0] && !enable[IEM_IN_CONV_LSB] && !status[IEM_IN_CONV_LSB])
      |=> !status[IEM_IN_CONV_LSB])
    else $error("Disabled input converter event set status.");
  chk_in_frame_shut: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (events_i.in_seq_frame_done && !enable[IEM_IN_SEQ_FRAME_BIT] && !status[IEM_IN_SEQ_FRAME_BIT])
      |=> !status[IEM_IN_SEQ_FRAME_BIT])
    else $error("Disabled input sequencer frame event set status.");
  chk_xfer_shut: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (events_i.in_seq_transfer_end && !enable[IEM_IN_SEQ_XFER_BIT] && !status[IEM_IN_SEQ_XFER_BIT])
      |=> !status[IEM_IN_SEQ_XFER_BIT])
    else $error("Disabled transfer end event set status.");
  chk_out_frame_shut: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (events_i.out_seq_frame_done && !enable[IEM_OUT_SEQ_FRAME_BIT]
      && !status[IEM_OUT_SEQ_FRAME_BIT]) |=> !status[IEM_OUT_SEQ_FRAME_BIT])
    else $error("Disabled output sequencer frame event set status.");
  chk_buf_shut: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (events_i.out_seq_buffer_done && !enable[IEM_OUT_SEQ_BUF_BIT] && !status[IEM_OUT_SEQ_BUF_BIT])
      |=> !status[IEM_OUT_SEQ_BUF_BIT])
    else $error("Disabled buffer done event set status.");

  // The gate is the enable of the event cycle, not the value written at that edge.
  sequence s_gate_opens_late;
    events_i.frame_start && !enable[IEM_FRAME_START_BIT] && !status[IEM_FRAME_START_BIT]
      && wr_enable && req.sel[3] && req.dat[IEM_FRAME_START_BIT];
  endsequence
  chk_late_gate_blocks: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_gate_opens_late |=> !status[IEM_FRAME_START_BIT])
    else $error("Event latched through an enable that was not yet set.");

  // A clear that meets an enabled event of the same source loses, so no event is lost.
  sequence s_clear_meets_event;
    clear_vec[IEM_FRAME_START_BIT] && events_i.frame_start && enable[IEM_FRAME_START_BIT];
  endsequence
  chk_set_beats_clear: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_clear_meets_event |=> status[IEM_FRAME_START_BIT])
    else $error("Clear removed a status bit set in the same cycle.");

  // Turning a gate off leaves its pending bit in place; only a clear removes it.
  chk_disable_keeps: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (status[IEM_FRAME_PERIOD_BIT] && wr_enable && !clear_vec[IEM_FRAME_PERIOD_BIT])
      |=> status[IEM_FRAME_PERIOD_BIT])
    else $error("Disabling a source removed its pending status.");

  // Reset leaves every enable off and the bus and interrupt quiet; this check
  // watches reset itself, so reset does not disable it.
  chk_reset_clears: assert property (@(posedge ref_clk_i)
    !nrst_i |=> (enable == IEM_ENABLE_RST) && !wb_ack_o && !irq_o)
    else $error("Reset did not clear the enables and outputs.");

  // Byte lanes left out of a write keep their value.
  chk_lane_write: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (wr_enable && (req.sel == 4'h8)) |=> (enable[23:0] == $past(enable[23:0])))
    else $error("Unselected enable byte lanes changed on a write.");

  // Read data is the register as it stood at the take edge, and zero outside the answer.
  sequence s_read_enable;
    take && !req.we && (req.adr == IEM_ENABLE_OFS);
  endsequence
  sequence s_read_clear;
    take && !req.we && (req.adr == IEM_CLEAR_OFS);
  endsequence
  chk_read_enable: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_read_enable |=> wb_ack_o && (wb_dat_o == $past(enable)))
    else $error("Enable register read returned a wrong value.");
  chk_read_clear_zero: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_read_clear |=> wb_ack_o && (wb_dat_o == IEM_ZERO_WORD))
    else $error("Clear register read was not zero.");
  chk_idle_data_zero: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !wb_ack_o |-> (wb_dat_o == IEM_ZERO_WORD))
    else $error("Read data not zero outside the answer.");
  chk_reserved_read: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    wb_ack_o |-> ((wb_dat_o & ~IEM_ENABLE_MASK) == IEM_ZERO_WORD))
    else $error("Reserved bit read as one.");

  // The interrupt line stands while an enabled status bit is pending.
  chk_irq_raised: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (status[IEM_FRAME_START_BIT] && irq_en[IEM_FRAME_START_BIT]) |-> irq_o)
    else $error("Interrupt low with an enabled status bit pending.");
endmodule
`default_nettype wire

// ===== hdl/iem_pkg.sv
// Package for the interrupt enable and mask block: register map, field
// positions, reset values and the structs that carry event groups.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package iem_pkg;

  // Register byte offsets.
  localparam logic [11:0] IEM_ENABLE_OFS = 12'h36c;
  localparam logic [11:0] IEM_STATUS_OFS = 12'h380;
  localparam logic [11:0] IEM_CLEAR_OFS = 12'h384;
  localparam logic [11:0] IEM_IRQ_EN_OFS = 12'h388;

  // Enable register field positions.
  localparam int IEM_OUT_SEQ_BUF_BIT = 0;
  localparam int IEM_OUT_SEQ_FRAME_BIT = 4;
  localparam int IEM_IN_SEQ_XFER_BIT = 8;
  localparam int IEM_IN_SEQ_FRAME_BIT = 12;
  localparam int IEM_OUT_CONV_LSB = 16;
  localparam int IEM_IN_CONV_LSB = 24;
  localparam int IEM_FRAME_START_BIT = 28;
  localparam int IEM_FRAME_PERIOD_BIT = 29;

  // Defined bits of the enable register; all others are reserved.
  localparam logic [31:0] IEM_ENABLE_MASK = 32'h3f03_1111;
  localparam logic [31:0] IEM_ENABLE_RST = 32'h0000_0000;
  localparam logic [31:0] IEM_STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] IEM_ZERO_WORD = 32'h0000_0000;

  // Event pulses from the converters and sequencers, one cycle each.
  typedef struct packed {
    logic frame_period;
    logic frame_start;
    logic [3:0] in_conv_done;
    logic [1:0] out_conv_event;
    logic in_seq_frame_done;
    logic in_seq_transfer_end;
    logic out_seq_frame_done;
    logic out_seq_buffer_done;
  } iem_event_type;

  // Classic Wishbone request as seen by the slave.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } iem_wb_req_type;

endpackage

// ===== hdl/iem_byte_reg.sv
// One byte lane of a writable register with a per-bit implemented mask.
// Assumes the caller gives a one-cycle write strobe for this lane.
`timescale 1ns/1ps
`default_nettype none
module iem_byte_reg
  import iem_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic wr_i,
  input wire logic [7:0] din_i,
  input wire logic [7:0] mask_i,
  output logic [7:0] q_o
);
  logic [7:0] q;
  logic [7:0] next_q;

  // Unimplemented bits never take a written value, so they read as zero.
  always_comb begin
    next_q = q;
    if (wr_i) begin
      next_q = din_i & mask_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= IEM_ENABLE_RST[7:0];
    end else begin
      q <= next_q;
    end
  end

  assign q_o = q;
endmodule
`default_nettype wire

// ===== hdl/iem_status_bit.sv
// One sticky interrupt status bit, set by a gated event, cleared by software.
// Assumes event pulses are synchronous to ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
module iem_status_bit
  import iem_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic event_i,
  input wire logic enable_i,
  input wire logic clear_i,
  output logic status_o
);
  logic status;
  logic next_status;

  // A gated event wins over a clear in the same cycle so nothing is lost.
  always_comb begin
    next_status = status;
    if (clear_i) begin
      next_status = 1'b0;
    end
    if (event_i && enable_i) begin
      next_status = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status <= 1'b0;
    end else begin
      status <= next_status;
    end
  end

  assign status_o = status;
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the interrupt enable block: enable register access,
// event gating, sticky status, clear register and the interrupt output.
// Assumes the design package is compiled first and one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import iem_pkg::*;
;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic [31:0] enable_q;
  logic irq;
  iem_event_type ev = '0;
  iem_event_type e;
  iem_event_type fs;
  logic [31:0] rd;
  logic [31:0] all;
  logic [31:0] w;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;

  // Free-running 25 ns clock.
  always #12.5 ref_clk = ~ref_clk;

  iem_top dut (
    .ref_clk_i(ref_clk),
    .nrst_i(nrst),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_sel_i(sel),
    .wb_adr_i(adr),
    .wb_dat_i(wdat),
    .wb_dat_o(rdat),
    .wb_ack_o(ack),
    .events_i(ev),
    .enable_o(enable_q),
    .irq_o(irq)
  );

  // Expected status bits for a set of event pulses, placed by the enable layout.
  function automatic logic [31:0] ev_map(input iem_event_type x);
    logic [31:0] m;
    m = 32'h0000_0000;
    m[29] = x.frame_period;
    m[28] = x.frame_start;
    m[27:24] = x.in_conv_done;
    m[17:16] = x.out_conv_event;
    m[12] = x.in_seq_frame_done;
    m[8] = x.in_seq_transfer_end;
    m[4] = x.out_seq_frame_done;
    m[0] = x.out_seq_buffer_done;
    return m;
  endfunction

  task automatic final_report;
    $display("Comparisons: %0d, mismatches: %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; the request is held until ack is seen at an edge.
  task automatic wb(input logic w_i, input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_i;
    adr <= a;
    wdat <= d;
    sel <= s;
    // Only the bench timeout ends this wait; a missing answer hangs into it.
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    // The answer stands one cycle after the take edge.
    check(32'(n), 32'h0000_0002);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000, 4'hf);
    check(rd, exp);
  endtask

  // Events last exactly one cycle, as the sources give them.
  task automatic pulse(input iem_event_type x);
    @(posedge ref_clk);
    ev <= x;
    @(posedge ref_clk);
    ev <= '0;
  endtask

  // A hang ends the run; the ceiling is well above the expected length.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      final_report;
    end
  end

  initial begin
    void'($urandom(36));
    all = ev_map('1);
    fs = '0;
    fs.frame_start = 1'b1;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    check(enable_q, 32'h0000_0000);
    rdchk(IEM_ENABLE_OFS, 32'h0000_0000);
    wr(IEM_ENABLE_OFS, 32'hffff_ffff);
    rdchk(IEM_ENABLE_OFS, all);
    check(enable_q, all);
    wb(1'b1, IEM_ENABLE_OFS, 32'h0000_0000, 4'b1000);
    rdchk(IEM_ENABLE_OFS, all & 32'h00ff_ffff);
    rdchk(12'h370, 32'h0000_0000);
    // Only one source enabled while every source fires.
    for (int i = 0; i < 12; i++) begin
      e = iem_event_type'(12'h001 << i);
      wr(IEM_ENABLE_OFS, ev_map(e));
      wr(IEM_CLEAR_OFS, 32'hffff_ffff);
      pulse('1);
      rdchk(IEM_STATUS_OFS, ev_map(e));
    end
    // Random masks and events; disabling afterwards must keep what latched.
    repeat (40) begin
      w = $urandom;
      e = iem_event_type'(12'($urandom_range(0, 4095)));
      wr(IEM_ENABLE_OFS, w);
      rdchk(IEM_ENABLE_OFS, w & all);
      wr(IEM_CLEAR_OFS, 32'hffff_ffff);
      pulse(e);
      rdchk(IEM_STATUS_OFS, ev_map(e) & w);
      wr(IEM_ENABLE_OFS, 32'h0000_0000);
      pulse('1);
      rdchk(IEM_STATUS_OFS, ev_map(e) & w);
    end
    // Interrupt output: masked, raised, kept past disable, then cleared.
    wr(IEM_ENABLE_OFS, all);
    wr(IEM_CLEAR_OFS, 32'hffff_ffff);
    wr(IEM_IRQ_EN_OFS, 32'h0000_0000);
    pulse(fs);
    #1;
    check({31'h0, irq}, 32'h0000_0000);
    wr(IEM_IRQ_EN_OFS, 32'hffff_ffff);
    #1;
    check({31'h0, irq}, 32'h0000_0001);
    rdchk(IEM_IRQ_EN_OFS, all);
    rdchk(IEM_CLEAR_OFS, 32'h0000_0000);
    wr(IEM_ENABLE_OFS, 32'h0000_0000);
    #1;
    check({31'h0, irq}, 32'h0000_0001);
    wr(IEM_CLEAR_OFS, ev_map(fs));
    #1;
    check({31'h0, irq}, 32'h0000_0000);
    rdchk(IEM_STATUS_OFS, 32'h0000_0000);
    // An enable written at the very edge that sees the event comes too late.
    fork
      wr(IEM_ENABLE_OFS, ev_map(fs));
      pulse(fs);
    join
    rdchk(IEM_STATUS_OFS, 32'h0000_0000);
    // A clear taken at the edge that sees an enabled event loses to it.
    fork
      wr(IEM_CLEAR_OFS, ev_map(fs));
      pulse(fs);
    join
    rdchk(IEM_STATUS_OFS, ev_map(fs));
    // A second reset in mid-run returns enables, status and the interrupt to zero.
    wr(IEM_ENABLE_OFS, all);
    pulse('1);
    #1;
    check({31'h0, irq}, 32'h0000_0001);
    @(posedge ref_clk);
    nrst <= 1'b0;
    @(posedge ref_clk);
    nrst <= 1'b1;
    #1;
    check(enable_q, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    rdchk(IEM_STATUS_OFS, 32'h0000_0000);
    rdchk(IEM_ENABLE_OFS, 32'h0000_0000);
    final_report;
  end
endmodule
`default_nettype wire
